// ===== core/dpll_phase_ctrl.sv
`timescale 1ns/10ps
module dpll_phase_ctrl
   import dpll_phase_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Register port
   input wire reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   // Profile configuration
   input wire profile_s profile,
   input wire logic mf_enable,
   // Multifunction pins, asynchronous
   input wire logic mf_incr,
   input wire logic mf_decr,
   input wire logic mf_clear,
   // Reference pin, asynchronous
   input wire logic ref_in,
   // Converter interface
   output logic tdc_strobe,
   input wire logic tdc_valid,
   input wire logic [39:0] tdc_word,
   // Synthesizer interface
   input wire logic dds_rollover,
   input wire logic [39:0] dds_stamp,
   output logic tune_valid,
   output logic [47:0] tune_word
);

   logic [39:0] fixed_off_ff;
   logic [15:0] step_size_ff;
   logic [15:0] slew_lim_ff;
   logic signed [39:0] incr_acc_ff;
   logic [2:0] ref_sync_ff;
   logic [29:0] ref_cnt_ff;
   logic [2:0] mf_meta_ff, mf_sync_ff, mf_prev_ff;
   logic [20:0] fb_cnt_ff;
   logic [9:0] frac_acc_ff;
   logic fb_extra_ff;
   logic signed [39:0] fb_word_ff;
   logic signed [39:0] eff_off_ff;
   logic [31:0] off_frac_ff;
   logic [63:0] budget_ff;
   logic signed [39:0] prev_err_ff;
   logic signed [39:0] integ_ff;
   logic integ_valid_ff;
   logic signed [47:0] s1_ff, s2_ff, s3_ff;

   // Coefficient: x * frac * 2^-neg_exp * 2^pos_a * 2^pos_b
   // Right shifts go first; alpha gains its size from the left shifts
   function automatic logic signed [47:0] coef_mul(input logic signed [47:0] x,
                                                   input coef_s c);
      logic signed [64:0] prod;
      prod = x * $signed({1'b0, c.frac});
      prod = prod >>> 16;
      prod = prod >>> c.neg_exp;
      prod = prod <<< c.pos_a;
      prod = prod <<< c.pos_b;
      return prod[47:0];
   endfunction

   // Register decode
   // Multi-byte fields land byte by byte; software sees partial updates
   wire wr_fixed = reg_req.wr && reg_req.addr >= ADDR_FIXED_OFF &&
                   reg_req.addr < ADDR_FIXED_OFF + 16'(FIXED_BYTES);
   wire wr_step = reg_req.wr && reg_req.addr >= ADDR_STEP_SIZE &&
                  reg_req.addr < ADDR_STEP_SIZE + 16'(STEP_BYTES);
   wire wr_slew = reg_req.wr && reg_req.addr >= ADDR_SLEW_LIM &&
                  reg_req.addr < ADDR_SLEW_LIM + 16'(SLEW_BYTES);
   wire wr_ctrl = reg_req.wr && reg_req.addr == ADDR_STEP_CTRL;
   wire [2:0] fix_idx = 3'(reg_req.addr - ADDR_FIXED_OFF);
   wire step_idx = reg_req.addr[0] ^ ADDR_STEP_SIZE[0];
   wire slew_idx = reg_req.addr[0] ^ ADDR_SLEW_LIM[0];

   always_ff @(posedge clock) begin
      if (!nrst) begin
         fixed_off_ff <= FIXED_OFF_RST;
      end else if (wr_fixed) begin
         fixed_off_ff[fix_idx*8 +: 8] <= reg_req.wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         step_size_ff <= STEP_SIZE_RST;
      end else if (wr_step) begin
         step_size_ff[step_idx*8 +: 8] <= reg_req.wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         slew_lim_ff <= SLEW_LIM_RST;
      end else if (wr_slew) begin
         slew_lim_ff[slew_idx*8 +: 8] <= reg_req.wdata;
      end
   end

   // Multifunction pins: two-stage sync, then rising edge
   // Third stage is the edge detector's memory, never read raw
   always_ff @(posedge clock) begin
      if (!nrst) begin
         mf_meta_ff <= 3'h0;
         mf_sync_ff <= 3'h0;
         mf_prev_ff <= 3'h0;
      end else begin
         mf_meta_ff <= {mf_clear, mf_decr, mf_incr};
         mf_sync_ff <= mf_meta_ff;
         mf_prev_ff <= mf_sync_ff;
      end
   end

   // Edges count only while the pins are enabled
   wire [2:0] mf_rise = mf_sync_ff & ~mf_prev_ff & {3{mf_enable}};

   // Control bits act in the write cycle and never store, so read back zero
   // A pin edge and a write in one cycle merge into one action
   wire do_incr = (wr_ctrl && reg_req.wdata[BIT_INCR]) || mf_rise[0];
   wire do_decr = (wr_ctrl && reg_req.wdata[BIT_DECR]) || mf_rise[1];
   wire do_clr = (wr_ctrl && reg_req.wdata[BIT_CLR]) || mf_rise[2];

   // Step accumulator is separate from the fixed offset
   // Clear wins over a step that lands in the same cycle
   wire signed [39:0] step_ps = $signed({24'h0, step_size_ff});

   always_ff @(posedge clock) begin
      if (!nrst) begin
         incr_acc_ff <= '0;
      end else if (do_clr) begin
         incr_acc_ff <= '0;
      end else if (do_incr && !do_decr) begin
         incr_acc_ff <= incr_acc_ff + step_ps;
      end else if (do_decr && !do_incr) begin
         incr_acc_ff <= incr_acc_ff - step_ps;
      end
   end

   // Effective offset tracking the target, slew limited when enabled
   // Target moves at once; only the effective offset is rate limited
   wire slew_on = slew_lim_ff != 16'h0000;
   wire signed [39:0] tgt_off = $signed(fixed_off_ff) + incr_acc_ff;
   wire [31:0] slew_inc = 32'(slew_lim_ff * SLEW_SCALE);
   // Fraction keeps sub-picosecond progress so small limits still move
   wire [32:0] off_frac_sum = {1'b0, off_frac_ff} + {1'b0, slew_inc};
   wire slewing = slew_on && eff_off_ff != tgt_off;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         eff_off_ff <= '0;
         off_frac_ff <= '0;
      end else if (!slew_on) begin
         eff_off_ff <= tgt_off;
         off_frac_ff <= '0;
      end else if (eff_off_ff == tgt_off) begin
         off_frac_ff <= '0;
      end else begin
         off_frac_ff <= off_frac_sum[31:0];
         if (off_frac_sum[32]) begin
            eff_off_ff <= (eff_off_ff < tgt_off) ? eff_off_ff + 40'sd1
                                                 : eff_off_ff - 40'sd1;
         end
      end
   end

   // Reference prescaler on the synchronised pin
   // Stage one feeds only stage two; stage three is the edge memory
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ref_sync_ff <= 3'h0;
      end else begin
         ref_sync_ff <= {ref_sync_ff[1:0], ref_in};
      end
   end

   wire ref_edge = ref_sync_ff[1] && !ref_sync_ff[2];
   wire ref_wrap = ref_cnt_ff >= profile.r_div;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ref_cnt_ff <= '0;
         tdc_strobe <= 1'b0;
      end else begin
         tdc_strobe <= 1'b0;
         if (ref_edge) begin
            if (ref_wrap) begin
               ref_cnt_ff <= '0;
               tdc_strobe <= 1'b1;
            end else begin
               ref_cnt_ff <= ref_cnt_ff + 30'd1;
            end
         end
      end
   end

   // Feedback divider, S+1 rollovers plus one more on fractional carry
   wire [10:0] frac_sum = {1'b0, frac_acc_ff} + {1'b0, profile.u_num};
   wire frac_carry = profile.v_den != 10'h000 && frac_sum >= {1'b0, profile.v_den};
   // One stretched cycle per carry realises the fraction on average
   wire [20:0] fb_mod = {1'b0, profile.s_int} + {20'h0, fb_extra_ff};
   wire fb_wrap = fb_cnt_ff >= fb_mod;
   // Residue times unit fits 26 bits, so the product cannot overflow
   wire [25:0] corr_ps = {16'h0, frac_acc_ff} * {10'h0, profile.frac_unit_ps};
   wire signed [39:0] frac_corr = $signed({14'h0, corr_ps});

   always_ff @(posedge clock) begin
      if (!nrst) begin
         fb_cnt_ff <= '0;
         frac_acc_ff <= '0;
         fb_extra_ff <= 1'b0;
         fb_word_ff <= '0;
      end else if (dds_rollover) begin
         if (fb_wrap) begin
            fb_cnt_ff <= '0;
            // Edge lands early by the residue; add it back as time
            fb_word_ff <= $signed(dds_stamp) + frac_corr;
            if (frac_carry) begin
               frac_acc_ff <= 10'(frac_sum - {1'b0, profile.v_den});
               fb_extra_ff <= 1'b1;
            end else begin
               frac_acc_ff <= profile.v_den == 10'h000 ? 10'h000 : frac_sum[9:0];
               fb_extra_ff <= 1'b0;
            end
         end else begin
            fb_cnt_ff <= fb_cnt_ff + 21'd1;
         end
      end
   end

   // Phase detector with slew clamp on error change
   // Only the change is clamped, so a steady offset still pulls the loop
   wire signed [39:0] raw_err = $signed(tdc_word) - fb_word_ff - eff_off_ff;
   wire signed [39:0] err_delta = raw_err - prev_err_ff;
   wire signed [39:0] budget_ps = $signed({8'h0, budget_ff[63:SLEW_FRAC_W]});
   logic signed [39:0] err;

   always_comb begin
      err = raw_err;
      if (slew_on) begin
         if (err_delta > budget_ps) begin
            err = prev_err_ff + budget_ps;
         end else if (err_delta < -budget_ps) begin
            err = prev_err_ff - budget_ps;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         budget_ff <= '0;
         prev_err_ff <= '0;
      end else if (tdc_valid) begin
         budget_ff <= {32'h0, slew_inc};
         prev_err_ff <= err;
      end else if (budget_ff[63:62] == 2'b00) begin
         // Stops short of wrapping across long sample gaps
         budget_ff <= budget_ff + {32'h0, slew_inc};
      end
   end

   // Code pump clamps the error, integrator accumulates it
   // The clamp keeps one wild sample from winding the integrator far
   logic signed [39:0] pump;

   always_comb begin
      pump = err;
      if (err > PUMP_MAX) begin
         pump = PUMP_MAX;
      end else if (err < -PUMP_MAX) begin
         pump = -PUMP_MAX;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         integ_ff <= '0;
         integ_valid_ff <= 1'b0;
      end else begin
         integ_valid_ff <= tdc_valid;
         if (tdc_valid) begin
            integ_ff <= integ_ff + pump;
         end
      end
   end

   // Third-order IIR loop filter
   // States move only on a sample, so the filter runs at detector rate
   wire signed [47:0] x = 48'(integ_ff);
   wire signed [47:0] s1_n = s1_ff + coef_mul(x, profile.beta);
   wire signed [47:0] s2_n = s2_ff + coef_mul(s1_n - s2_ff, profile.gamma);
   wire signed [47:0] s3_n = s3_ff + coef_mul(s2_n - s3_ff, profile.delta);
   wire signed [47:0] y = coef_mul(x, profile.alpha) + s3_n;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else if (integ_valid_ff) begin
         s1_ff <= s1_n;
         s2_ff <= s2_n;
         s3_ff <= s3_n;
      end
   end

   // Word holds between samples so the synthesizer never sees a gap
   always_ff @(posedge clock) begin
      if (!nrst) begin
         tune_valid <= 1'b0;
         tune_word <= '0;
      end else begin
         tune_valid <= integ_valid_ff;
         if (integ_valid_ff) begin
            tune_word <= profile.base_tune + y;
         end
      end
   end

   // Register read mux; unmapped addresses read zero
   logic [7:0] nxt_rdata;

   always_comb begin
      nxt_rdata = 8'h00;
      if (reg_req.addr >= ADDR_FIXED_OFF &&
          reg_req.addr < ADDR_FIXED_OFF + 16'(FIXED_BYTES)) begin
         nxt_rdata = fixed_off_ff[fix_idx*8 +: 8];
      end else if (reg_req.addr >= ADDR_STEP_SIZE &&
                   reg_req.addr < ADDR_STEP_SIZE + 16'(STEP_BYTES)) begin
         nxt_rdata = step_size_ff[step_idx*8 +: 8];
      end else if (reg_req.addr >= ADDR_SLEW_LIM &&
                   reg_req.addr < ADDR_SLEW_LIM + 16'(SLEW_BYTES)) begin
         nxt_rdata = slew_lim_ff[slew_idx*8 +: 8];
      end else if (reg_req.addr == ADDR_STEP_CTRL) begin
         nxt_rdata[BIT_SLEWING] = slewing;
      end
   end

   // Data one cycle after the strobe, held until the next read
   always_ff @(posedge clock) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd) begin
         reg_rdata <= nxt_rdata;
      end
   end

endmodule

// ===== core/dpll_phase_pkg.sv
package dpll_phase_pkg;
   // Byte-wide register map, multi-byte fields little endian
   localparam logic [15:0] ADDR_FIXED_OFF = 16'h030f;
   localparam logic [15:0] ADDR_STEP_SIZE = 16'h0314;
   localparam logic [15:0] ADDR_SLEW_LIM = 16'h0316;
   localparam logic [15:0] ADDR_STEP_CTRL = 16'h0a0c;
   localparam int FIXED_BYTES = 5;
   localparam int STEP_BYTES = 2;
   localparam int SLEW_BYTES = 2;
   localparam int BIT_INCR = 0;
   localparam int BIT_DECR = 1;
   localparam int BIT_CLR = 2;
   localparam int BIT_SLEWING = 7;
   localparam logic [39:0] FIXED_OFF_RST = 40'h00_0000_0000;
   localparam logic [15:0] STEP_SIZE_RST = 16'h0000;
   localparam logic [15:0] SLEW_LIM_RST = 16'h0000;
   localparam int PHASE_W = 40;
   localparam int TUNE_W = 48;
   // Clock rate and slew scaling, 2^-32 ps fraction per clock per ns/s
   localparam longint CLK_PERIOD_PS = 4000;
   localparam int SLEW_FRAC_W = 32;
   localparam logic [31:0] SLEW_SCALE =
      32'((64'd1 << SLEW_FRAC_W) * CLK_PERIOD_PS / 64'd1000000000);
   localparam logic signed [39:0] PUMP_MAX = 40'sh00_007f_ffff;

   typedef struct packed {
      logic [15:0] frac;
      logic [5:0] neg_exp;
      logic [3:0] pos_a;
      logic [3:0] pos_b;
   } coef_s;

   typedef struct packed {
      logic [29:0] r_div;
      logic [19:0] s_int;
      logic [9:0] u_num;
      logic [9:0] v_den;
      logic [15:0] frac_unit_ps;
      logic [47:0] base_tune;
      coef_s alpha;
      coef_s beta;
      coef_s gamma;
      coef_s delta;
   } profile_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } reg_req_s;
endpackage

// ===== tb/dpll_far_model.sv
`timescale 1ns/10ps
module dpll_far_model (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   input wire logic run,
   // Reference and converter
   input wire logic tdc_strobe,
   output logic ref_in,
   output logic tdc_valid,
   output logic [39:0] tdc_word,
   // Synthesizer
   output logic dds_rollover,
   output logic [39:0] dds_stamp,
   output int ref_edges
);
   logic [1:0] ref_cnt_ff;
   logic [1:0] roll_cnt_ff;
   logic [1:0] conv_dly_ff;
   logic [39:0] now_ps_ff;

   // Reference toggles every third clock, idles low when stopped
   always_ff @(posedge clock) begin
      if (!nrst || !run) begin
         ref_cnt_ff <= 2'h0;
         ref_in <= 1'b0;
      end else begin
         ref_cnt_ff <= (ref_cnt_ff == 2'h2) ? 2'h0 : ref_cnt_ff + 2'h1;
         if (ref_cnt_ff == 2'h2) ref_in <= !ref_in;
      end
   end
   always_ff @(posedge clock) begin
      if (!nrst) ref_edges <= 0;
      else if (run && ref_cnt_ff == 2'h2 && !ref_in) ref_edges <= ref_edges + 1;
   end
   always_ff @(posedge clock) begin
      if (!nrst) now_ps_ff <= 40'h0;
      else now_ps_ff <= now_ps_ff + 40'd4000;
   end
   always_ff @(posedge clock) begin
      if (!nrst) roll_cnt_ff <= 2'h0;
      else roll_cnt_ff <= roll_cnt_ff + 2'h1;
      dds_rollover <= nrst && roll_cnt_ff == 2'h3;
      dds_stamp <= now_ps_ff;
   end
   // Converter answers three clocks after each divided edge
   always_ff @(posedge clock) begin
      conv_dly_ff <= nrst ? {conv_dly_ff[0], tdc_strobe} : 2'h0;
      tdc_valid <= conv_dly_ff[1];
      tdc_word <= now_ps_ff + 40'd1234;
   end
endmodule

// ===== tb/dpll_phase_ctrl_props.sv
`timescale 1ns/10ps
module dpll_phase_ctrl_chk
   import dpll_phase_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Register port
   input wire reg_req_s reg_req,
   input wire logic [7:0] reg_rdata,
   // Loop signals
   input wire logic ref_in,
   input wire logic tdc_strobe,
   input wire logic tdc_valid,
   input wire logic tune_valid,
   input wire logic [47:0] tune_word
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);

   chk_strobe_pulse: assert property (tdc_strobe |=> !tdc_strobe)
      else $error("converter strobe longer than one cycle");
   chk_strobe_cause: assert property (tdc_strobe |->
      $past(ref_in, 3) && !$past(ref_in, 4))
      else $error("converter strobe without a reference edge");
   chk_tune_latency: assert property (tdc_valid |-> ##2 tune_valid)
      else $error("tuning word missing two cycles after sample");
   chk_tune_cause: assert property (tune_valid |-> $past(tdc_valid, 2))
      else $error("tuning word without a converter sample");
   chk_tune_hold: assert property (!tune_valid |-> $stable(tune_word))
      else $error("tuning word moved between updates");
   chk_ctrl_selfclear: assert property (reg_req.rd && reg_req.addr == ADDR_STEP_CTRL
      |=> reg_rdata[2:0] == 3'h0)
      else $error("step control action bits read back set");
   chk_unmapped_zero: assert property (reg_req.rd && reg_req.addr == 16'h0100
      |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   cover property (tune_valid);
   cover property (tdc_strobe);
   cover property (reg_req.wr && reg_req.addr == ADDR_STEP_CTRL);
endmodule

bind dpll_phase_ctrl dpll_phase_ctrl_chk u_chk (.clock(clock), .nrst(nrst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .ref_in(ref_in), .tdc_strobe(tdc_strobe), .tdc_valid(tdc_valid),
   .tune_valid(tune_valid), .tune_word(tune_word));

// ===== tb/dpll_phase_ctrl_tb.sv
`timescale 1ns/10ps
module dpll_phase_ctrl_tb;
   import dpll_phase_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   reg_req_s reg_req = '0;
   profile_s prof = '0;
   logic mf_enable = 1'b0;
   logic [2:0] mf = 3'h0;
   logic run = 1'b0;
   logic [7:0] reg_rdata;
   logic ref_in, tdc_strobe, tdc_valid, dds_rollover, tune_valid;
   logic [39:0] tdc_word, dds_stamp, fixed_v;
   logic [47:0] tune_word;
   logic [7:0] b;
   logic [7:0] rd_q[$];
   logic rd_pend = 1'b0;
   logic [31:0] lfsr = 32'hc53a;
   int ref_edges;
   int strobes = 0;
   int err_count = 0;
   int comparisons = 0;

   always #2 clock = ~clock;

   dpll_phase_ctrl DUT (.clock(clock), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .profile(prof), .mf_enable(mf_enable), .mf_incr(mf[0]), .mf_decr(mf[1]),
      .mf_clear(mf[2]), .ref_in(ref_in), .tdc_strobe(tdc_strobe), .tdc_valid(tdc_valid),
      .tdc_word(tdc_word), .dds_rollover(dds_rollover), .dds_stamp(dds_stamp),
      .tune_valid(tune_valid), .tune_word(tune_word));
   dpll_far_model far (.clock(clock), .nrst(nrst), .run(run), .tdc_strobe(tdc_strobe),
      .ref_in(ref_in), .tdc_valid(tdc_valid), .tdc_word(tdc_word),
      .dds_rollover(dds_rollover), .dds_stamp(dds_stamp), .ref_edges(ref_edges));

   task check(input logic [47:0] seen, input logic [47:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic [7:0] get8();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction
   // A spare cycle between accesses keeps strobes from being reassigned
   task reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      @(negedge clock);
      reg_req.wr = 1'b0;
   endtask
   task reg_rd(input logic [15:0] a, input logic [7:0] e);
      @(negedge clock);
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      rd_q.push_back(e);
      @(negedge clock);
      reg_req.rd = 1'b0;
   endtask
   task mf_pulse(input int k);
      @(negedge clock);
      mf[k] = 1'b1;
      repeat (3) @(negedge clock);
      mf[k] = 1'b0;
      repeat (6) @(negedge clock);
   endtask

   always @(posedge clock) rd_pend <= reg_req.rd && nrst;
   always @(negedge clock) begin
      if (rd_pend) check(48'(reg_rdata), 48'(rd_q.pop_front()));
      if (tune_valid) check(tune_word, prof.base_tune);
      if (tdc_strobe) strobes++;
   end

   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      report_and_stop;
   end

   initial begin
      prof.r_div = 30'd2;
      prof.s_int = 20'd7;
      prof.base_tune = {lfsr[15:0], lfsr};
      repeat (2) @(posedge clock);
      @(negedge clock) nrst = 1'b1;
      reg_rd(ADDR_SLEW_LIM, 8'h00);
      reg_rd(ADDR_SLEW_LIM + 16'd1, 8'h00);
      for (int i = 0; i < FIXED_BYTES; i++) begin
         b = get8();
         fixed_v[8*i +: 8] = b;
         reg_wr(ADDR_FIXED_OFF + 16'(i), b);
      end
      for (int i = 0; i < FIXED_BYTES; i++) reg_rd(ADDR_FIXED_OFF + 16'(i), fixed_v[8*i +: 8]);
      reg_wr(ADDR_STEP_SIZE, 8'h10);
      reg_wr(ADDR_STEP_SIZE + 16'd1, 8'h00);
      reg_rd(ADDR_STEP_SIZE, 8'h10);
      reg_rd(ADDR_STEP_SIZE + 16'd1, 8'h00);
      reg_wr(ADDR_STEP_CTRL, 8'h01);
      reg_rd(ADDR_STEP_CTRL, 8'h00);
      reg_wr(ADDR_STEP_CTRL, 8'h02);
      // Small limit so the walk lasts long enough to be seen
      b = get8();
      b[0] = 1'b1;
      reg_wr(ADDR_SLEW_LIM, b);
      reg_wr(ADDR_SLEW_LIM + 16'd1, 8'h00);
      reg_rd(ADDR_SLEW_LIM, b);
      reg_wr(ADDR_STEP_CTRL, 8'h03);
      reg_rd(ADDR_STEP_CTRL, 8'h00);
      reg_wr(ADDR_STEP_CTRL, 8'h01);
      reg_rd(ADDR_STEP_CTRL, 8'h80);
      reg_wr(ADDR_STEP_CTRL, 8'h02);
      reg_rd(ADDR_STEP_CTRL, 8'h00);
      reg_wr(ADDR_STEP_CTRL, 8'h01);
      reg_wr(ADDR_STEP_CTRL, 8'h04);
      reg_rd(ADDR_STEP_CTRL, 8'h00);
      for (int k = 0; k < 3; k++) mf_pulse(k);
      reg_rd(ADDR_STEP_CTRL, 8'h00);
      mf_enable = 1'b1;
      mf_pulse(0);
      reg_rd(ADDR_STEP_CTRL, 8'h80);
      mf_pulse(2);
      reg_rd(ADDR_STEP_CTRL, 8'h00);
      mf_pulse(0);
      reg_wr(ADDR_SLEW_LIM, 8'h00);
      reg_rd(ADDR_STEP_CTRL, 8'h00);
      reg_wr(16'h0100, 8'hff);
      reg_rd(16'h0100, 8'h00);
      run = 1'b1;
      repeat (600) @(negedge clock);
      run = 1'b0;
      repeat (20) @(negedge clock);
      check(48'(strobes), 48'(ref_edges / 3));
      report_and_stop;
   end
endmodule
